// *** core/bmsd_pkg.sv ***
// Constants and types for the boot mode strap decoder
// Behaviour
// - At reset read straps, pick boot source
// - Pins 5:3 decode JTAG, QSPI, SD card
// - Pin 2 selects cascaded or independent JTAG
// - Pin 6 selects PLL used or bypassed
// - Pins 8:7 set bank voltages, fixed
// - Low pull-up input enables configuration pull-ups
// - Reconfigure when program request returns high
// - Done output asserted after configuration completes
// - Present mezzanine joins scan chain, else bypassed
// - Secure boot available, except on engineering samples (non-secure only)
package bmsd_pkg;

	localparam int STRAP_W       = 9;
	localparam int BOOT_LSB      = 3;
	localparam int BOOT_MSB      = 5;
	localparam int CHAIN_BIT     = 2;
	localparam int PLL_BIT       = 6;
	localparam int VMODE_LSB     = 7;
	localparam int VMODE_MSB     = 8;
	localparam int SYNC_LEN      = 2;

	localparam logic [2:0] BOOT_CODE_JTAG = 3'h0;
	localparam logic [2:0] BOOT_CODE_QSPI = 3'h4;
	localparam logic [2:0] BOOT_CODE_SD   = 3'h6;

	// Fixed bank voltage strap: first bank 3.3V, second 1.8V
	localparam logic [1:0] VMODE_FIXED    = 2'h1;

	// Configuration load time, default 250 ms
	localparam int CFG_TIME_MS   = 250;
	localparam int CLK_HZ        = 10_000_000;
	localparam int CFG_CYCLES    = (CLK_HZ / 1000) * CFG_TIME_MS;

	typedef enum logic [2:0] {
		BMSD_BOOT_JTAG    = 3'b000,
		BMSD_BOOT_QSPI    = 3'b001,
		BMSD_BOOT_SD      = 3'b010,
		BMSD_BOOT_NOR     = 3'b011,
		BMSD_BOOT_NAND    = 3'b100,
		BMSD_BOOT_INVALID = 3'b111
	} bmsd_boot_type;

	typedef enum logic [1:0] {
		BMSD_ST_SAMPLE = 2'b00,
		BMSD_ST_CONFIG = 2'b01,
		BMSD_ST_DONE   = 2'b10,
		BMSD_ST_HOLD   = 2'b11
	} bmsd_state_type;

	function automatic bmsd_boot_type bmsd_decode_boot(input logic [2:0] code);
		bmsd_boot_type r;
		r = BMSD_BOOT_INVALID;
		if (code == BOOT_CODE_JTAG) begin
			r = BMSD_BOOT_JTAG;
		end else if (code == BOOT_CODE_QSPI) begin
			r = BMSD_BOOT_QSPI;
		end else if (code == BOOT_CODE_SD) begin
			r = BMSD_BOOT_SD;
		end
		return r;
	endfunction

endpackage

// *** core/bmsd_top.sv ***
// Boot mode strap decoder: strap capture, decode and configuration control
`timescale 1ns/100ps
`default_nettype none

module bmsd_top #(
	parameter int CFG_CYCLES_P = bmsd_pkg::CFG_CYCLES
) (
	input  wire logic                         CLK,
	input  wire logic                         RST_B,
	input  wire logic                         CE,
	input  wire logic [bmsd_pkg::STRAP_W-1:0] MULTIUSE_IO_PIN,
	input  wire logic                         CONFIG_PULLUP_ENABLE_N,
	input  wire logic                         PROGRAM_REQUEST_N,
	input  wire logic                         MEZZANINE_PRESENT,
	input  wire logic                         ENGINEERING_SAMPLE,
	output var  bmsd_pkg::bmsd_boot_type      BOOT_SOURCE,
	output var  logic                         CHAIN_INDEPENDENT,
	output var  logic                         PLL_BYPASS,
	output var  logic [1:0]                   BANK_VMODE,
	output var  logic                         STRAPS_VALID,
	output var  logic                         IO_PULLUP_EN,
	output var  logic                         CONFIGURING,
	output var  logic                         DONE,
	output var  logic                         MEZZANINE_IN_CHAIN,
	output var  logic                         SECURE_BOOT_AVAIL
);
	import bmsd_pkg::*;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	localparam int SW = STRAP_W + 4;
	// Program and pull-up inputs idle high, so reset to that level: no false release edge
	localparam logic [SW-1:0] SYNC_IDLE = {1'b0, 1'b0, 1'b1, 1'b1, {STRAP_W{1'b0}}};
	logic [SW-1:0] sync1_reg;
	logic [SW-1:0] sync2_reg;

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			sync1_reg <= SYNC_IDLE;
			sync2_reg <= SYNC_IDLE;
		end else if (CE) begin
			sync1_reg <= {ENGINEERING_SAMPLE, MEZZANINE_PRESENT, PROGRAM_REQUEST_N,
				CONFIG_PULLUP_ENABLE_N, MULTIUSE_IO_PIN};
			sync2_reg <= sync1_reg;
		end
	end

	wire logic [STRAP_W-1:0] strap_s   = sync2_reg[STRAP_W-1:0];
	wire logic               pullup_n_s = sync2_reg[STRAP_W];
	wire logic               program_request_n_n_s   = sync2_reg[STRAP_W+1];
	wire logic               mezz_s     = sync2_reg[STRAP_W+2];
	wire logic               es_s       = sync2_reg[STRAP_W+3];

	// ----------------------------------------
	// Control state
	// ----------------------------------------
	bmsd_state_type           state_reg, state_next;
	logic [SYNC_LEN-1:0]      settle_reg;
	logic [31:0]              cnt_reg, cnt_next;
	logic                     program_request_n_n_d_reg;
	logic [STRAP_W-1:0]       strap_reg;

	// Wait for the synchroniser to fill before capturing the straps
	wire logic settled = settle_reg[SYNC_LEN-1];
	wire logic program_request_n_release = program_request_n_n_s & ~program_request_n_n_d_reg;
	wire logic cfg_end      = (cnt_reg == 32'(CFG_CYCLES_P - 1));

	// Decode of the latched straps
	// Boot source select
	wire bmsd_boot_type boot_dec = bmsd_decode_boot(strap_reg[BOOT_MSB:BOOT_LSB]);

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		unique case (state_reg)
			BMSD_ST_SAMPLE: begin
				if (settled) begin
					state_next = BMSD_ST_CONFIG;
					cnt_next   = '0;
				end
			end
			BMSD_ST_CONFIG: begin
				if (cfg_end) begin
					state_next = BMSD_ST_DONE;
				end else begin
					cnt_next = cnt_reg + 32'h1;
				end
			end
			BMSD_ST_DONE: begin
				if (!program_request_n_n_s) begin
					state_next = BMSD_ST_HOLD;
				end
			end
			BMSD_ST_HOLD: begin
				if (program_request_n_release) begin
					state_next = BMSD_ST_CONFIG;
					cnt_next   = '0;
				end
			end
		endcase
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			state_reg    <= BMSD_ST_SAMPLE;
			settle_reg   <= '0;
			cnt_reg      <= '0;
			program_request_n_n_d_reg <= 1'b1;
		end else if (CE) begin
			state_reg    <= state_next;
			settle_reg   <= {settle_reg[SYNC_LEN-2:0], 1'b1};
			cnt_reg      <= cnt_next;
			program_request_n_n_d_reg <= program_request_n_n_s;
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			strap_reg <= '0;
		end else if (CE && state_reg == BMSD_ST_SAMPLE && settled) begin
			strap_reg <= strap_s;
		end
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	wire logic captured = (state_reg != BMSD_ST_SAMPLE);

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			BOOT_SOURCE        <= BMSD_BOOT_INVALID;
			CHAIN_INDEPENDENT  <= 1'b0;
			PLL_BYPASS         <= 1'b0;
			BANK_VMODE         <= VMODE_FIXED;
			STRAPS_VALID       <= 1'b0;
			IO_PULLUP_EN       <= 1'b0;
			CONFIGURING        <= 1'b0;
			DONE               <= 1'b0;
			MEZZANINE_IN_CHAIN <= 1'b0;
			SECURE_BOOT_AVAIL  <= 1'b0;
		end else if (CE) begin
			STRAPS_VALID       <= captured;
			BOOT_SOURCE        <= captured ? boot_dec : BMSD_BOOT_INVALID;
			CHAIN_INDEPENDENT  <= strap_reg[CHAIN_BIT];
			PLL_BYPASS         <= strap_reg[PLL_BIT];
			BANK_VMODE         <= captured ? strap_reg[VMODE_MSB:VMODE_LSB] : VMODE_FIXED;
			CONFIGURING        <= (state_next == BMSD_ST_CONFIG);
			IO_PULLUP_EN       <= (state_next == BMSD_ST_CONFIG) & ~pullup_n_s;
			DONE               <= (state_next == BMSD_ST_DONE);
			MEZZANINE_IN_CHAIN <= mezz_s;
			SECURE_BOOT_AVAIL  <= ~es_s;
		end
	end

endmodule

`default_nettype wire

// *** verif/bmsd_bench.sv ***
// Self-checking bench for the strap decoder
`timescale 1ns/100ps
`default_nettype none
module bmsd_bench;
	import bmsd_pkg::*;
	logic          clk, rst_b, pu, press, card, es, pun, prn, prs;
	logic          chain, pll, sv, pue, cfg, done, mic, sec, ce;
	logic [4:0]    jmp;
	logic [8:0]    pins;
	logic [1:0]    vm;
	bmsd_boot_type src;
	int            n_fail, checks_done;
	bmsd_board brd (.jumper(jmp), .pu_jumper(pu), .press(press), .card(card), .pins(pins),
		.pullup_n(pun), .program_request_n_n(prn), .present(prs));
	bmsd_top #(.CFG_CYCLES_P(10)) uut (.CLK(clk), .RST_B(rst_b), .CE(ce),
		.MULTIUSE_IO_PIN(pins), .CONFIG_PULLUP_ENABLE_N(pun), .PROGRAM_REQUEST_N(prn),
		.MEZZANINE_PRESENT(prs), .ENGINEERING_SAMPLE(es), .BOOT_SOURCE(src),
		.CHAIN_INDEPENDENT(chain), .PLL_BYPASS(pll), .BANK_VMODE(vm), .STRAPS_VALID(sv),
		.IO_PULLUP_EN(pue), .CONFIGURING(cfg), .DONE(done), .MEZZANINE_IN_CHAIN(mic),
		.SECURE_BOOT_AVAIL(sec));
	task automatic chk(input string n, input logic [8:0] s, input logic [8:0] e);
		checks_done++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected %s exp %h seen %h", n, e, s);
		end
	endtask
	// Inputs move 10 ns after the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#10;
	endtask
	task automatic wait_done;
		for (int i = 0; i < 40 && done !== 1'b1; i++) tick(1);
	endtask
	task automatic t_boot(input logic [4:0] j, input logic p, input bmsd_boot_type e);
		jmp = j;
		pu = p;
		rst_b = 1'b0;
		tick(12);
		rst_b = 1'b1;
		tick(1);
		chk("early", 9'({sv, src}), 9'(BMSD_BOOT_INVALID));
		tick(4);
		chk("pullup", 9'(pue), 9'(p));
		jmp = ~j;
		wait_done();
		chk("source", 9'(src), 9'(e));
		chk("chain_pll", 9'({chain, pll}), 9'({j[0], j[4]}));
		chk("vmode", 9'(vm), 9'(VMODE_FIXED));
		chk("valid", 9'(sv), 9'h1);
		chk("done", 9'({done, cfg}), 9'h2);
		$display("boot test finished");
	endtask
	task automatic t_program_request_n;
		press = 1'b1;
		tick(6);
		chk("press", 9'(done), 9'h0);
		press = 1'b0;
		tick(6);
		chk("restart", 9'(cfg), 9'h1);
		wait_done();
		chk("redone", 9'(done), 9'h1);
		$display("program test finished");
	endtask
	// A press and release while frozen must leave the block done
	task automatic t_freeze;
		ce = 1'b0;
		press = 1'b1;
		tick(6);
		chk("frozen", 9'(done), 9'h1);
		press = 1'b0;
		tick(6);
		ce = 1'b1;
		tick(6);
		chk("thawed", 9'({done, cfg}), 9'h2);
		$display("freeze test finished");
	endtask
	task automatic t_side(input logic c);
		card = c;
		es = c;
		tick(5);
		chk("side", 9'({mic, sec}), 9'({c, !c}));
		$display("side test finished");
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Whole run is some 150 cycles
	initial begin
		#300000;
		n_fail++;
		conclude();
	end
	initial begin
		{rst_b, pu, press, card, es} = 5'h0;
		jmp = 5'h0c;
		ce = 1'b1;
		n_fail = 0;
		checks_done = 0;
		t_boot(5'h0c, 1'b0, BMSD_BOOT_SD);
		t_boot(5'h10, 1'b1, BMSD_BOOT_JTAG);
		t_boot(5'h09, 1'b0, BMSD_BOOT_QSPI);
		t_boot(5'h1e, 1'b1, BMSD_BOOT_INVALID);
		t_program_request_n();
		t_freeze();
		t_side(1'b1);
		t_side(1'b0);
		conclude();
	end
endmodule
`default_nettype wire

// *** verif/bmsd_board.sv ***
// Board jumpers, program button and card presence
`timescale 1ns/100ps
`default_nettype none
module bmsd_board (
	input  wire logic [4:0] jumper,
	input  wire logic       pu_jumper,
	input  wire logic       press,
	input  wire logic       card,
	output logic      [8:0] pins,
	output logic            pullup_n,
	output logic            program_request_n_n,
	output logic            present
);
	// jumpers set pins 6:2; bank pins hard strapped
	assign pins = {bmsd_pkg::VMODE_FIXED, jumper, 2'h0};
	// pulled high unless the jumper is fitted
	assign pullup_n = !pu_jumper;
	assign program_request_n_n = !press;
	assign present = card;
endmodule
`default_nettype wire

// *** verif/bmsd_chk.sv ***
// Port assertions for the strap decoder
`timescale 1ns/100ps
`default_nettype none
module bmsd_chk
	import bmsd_pkg::*;
#(parameter int CFG_CYCLES_P = 10) (
	input wire logic                  CLK,
	input wire logic                  RST_B,
	input wire logic [STRAP_W-1:0]    MULTIUSE_IO_PIN,
	input wire logic                  PROGRAM_REQUEST_N,
	input wire logic                  MEZZANINE_PRESENT,
	input wire logic                  ENGINEERING_SAMPLE,
	input wire bmsd_pkg::bmsd_boot_type BOOT_SOURCE,
	input wire logic                  CHAIN_INDEPENDENT,
	input wire logic                  PLL_BYPASS,
	input wire logic [1:0]            BANK_VMODE,
	input wire logic                  STRAPS_VALID,
	input wire logic                  IO_PULLUP_EN,
	input wire logic                  CONFIGURING,
	input wire logic                  DONE,
	input wire logic                  MEZZANINE_IN_CHAIN,
	input wire logic                  SECURE_BOOT_AVAIL
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);
	wire logic [2:0] code = MULTIUSE_IO_PIN[5:3];
	wire bmsd_boot_type exp_src = code == BOOT_CODE_JTAG ? BMSD_BOOT_JTAG :
		code == BOOT_CODE_QSPI ? BMSD_BOOT_QSPI :
		code == BOOT_CODE_SD ? BMSD_BOOT_SD : BMSD_BOOT_INVALID;
	a_boot_decode: assert property (
		$rose(STRAPS_VALID) |-> BOOT_SOURCE == $past(exp_src)) else $error("bad boot source");
	a_chain_bit: assert property (
		$rose(STRAPS_VALID) |-> CHAIN_INDEPENDENT == $past(MULTIUSE_IO_PIN[2])) else $error("bad chain");
	a_pll_bit: assert property (
		$rose(STRAPS_VALID) |-> PLL_BYPASS == $past(MULTIUSE_IO_PIN[6])) else $error("bad pll");
	a_vmode_bits: assert property (
		$rose(STRAPS_VALID) |-> BANK_VMODE == $past(MULTIUSE_IO_PIN[8:7])) else $error("bad vmode");
	a_straps_hold: assert property (
		STRAPS_VALID && $past(STRAPS_VALID) |-> $stable({BOOT_SOURCE, CHAIN_INDEPENDENT,
		PLL_BYPASS, BANK_VMODE})) else $error("straps moved");
	a_done_time: assert property (
		$rose(CONFIGURING) |-> ##CFG_CYCLES_P (DONE && !CONFIGURING)) else $error("done late");
	a_pullup_cfg: assert property (
		IO_PULLUP_EN |-> CONFIGURING) else $error("pull-up outside config");
	a_program_request_n_restart: assert property (
		$rose(CONFIGURING) && $past(STRAPS_VALID) |-> $past(PROGRAM_REQUEST_N))
		else $error("restart without release");
	a_mezz_follow: assert property (
		$stable(MEZZANINE_PRESENT)[*4] |-> MEZZANINE_IN_CHAIN == MEZZANINE_PRESENT)
		else $error("chain presence wrong");
	a_secure_avail: assert property (
		$stable(ENGINEERING_SAMPLE)[*4] |-> SECURE_BOOT_AVAIL != ENGINEERING_SAMPLE)
		else $error("secure flag wrong");
	c_done: cover property ($rose(DONE));
	c_restart: cover property ($rose(CONFIGURING) && $past(STRAPS_VALID));
	c_pullup: cover property (IO_PULLUP_EN);
endmodule
bind bmsd_top bmsd_chk #(.CFG_CYCLES_P(CFG_CYCLES_P)) chk_i (.CLK(CLK), .RST_B(RST_B),
	.MULTIUSE_IO_PIN(MULTIUSE_IO_PIN), .PROGRAM_REQUEST_N(PROGRAM_REQUEST_N),
	.MEZZANINE_PRESENT(MEZZANINE_PRESENT), .ENGINEERING_SAMPLE(ENGINEERING_SAMPLE),
	.BOOT_SOURCE(BOOT_SOURCE), .CHAIN_INDEPENDENT(CHAIN_INDEPENDENT), .PLL_BYPASS(PLL_BYPASS),
	.BANK_VMODE(BANK_VMODE), .STRAPS_VALID(STRAPS_VALID), .IO_PULLUP_EN(IO_PULLUP_EN),
	.CONFIGURING(CONFIGURING), .DONE(DONE), .MEZZANINE_IN_CHAIN(MEZZANINE_IN_CHAIN),
	.SECURE_BOOT_AVAIL(SECURE_BOOT_AVAIL));
`default_nettype wire
